//--- rtl/qsb_ctl.sv
/*
  Memory controller end: makes K and /K by dividing I_CLK by four, runs the
  clock setup wait, issues one read or write burst at a time.
  Assumes the user holds a request until O_REQ_READY takes it.
*/
`timescale 1ns/100ps
`include "qsb_defines.svh"
`default_nettype none

module qsb_ctl #(
  parameter int DW = `QSB_DATA_W,
  parameter int AW = `QSB_ADDR_W
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PLL_ON,
  input wire logic I_RD_REQ,
  input wire logic I_WR_REQ,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [4*DW-1:0] I_WDATA,
  input wire logic [4*(DW/`QSB_LANE_W)-1:0] I_WBE_N,
  output logic O_REQ_READY,
  output logic O_SETUP_DONE,
  output logic [4*DW-1:0] O_RDATA,
  output logic O_RDATA_VLD,
  output qsb_pkg::qsb_ctl_state_e O_STATE,
  qsb_link_if.ctl LINK
);
  import qsb_pkg::*;

  localparam int LANES = DW / `QSB_LANE_W;
  localparam int K_MHZ = `QSB_CLK_MHZ / `QSB_K_DIV;
  localparam int SETUP_CYC = `QSB_SETUP_CYC;
  localparam int SW = $clog2(SETUP_CYC + 1);

  if ((DW != 18 && DW != 36) || AW < 1 || `QSB_K_DIV != 4) begin : g_bad_size
    $error("qsb_ctl: unsupported width or clock divider");
  end

  qsb_ctl_state_e st_r;
  qsb_ctl_state_e st_nxt;
  logic [1:0] ph_r;
  logic k_r;
  logic kn_r;
  logic [SW-1:0] cnt_r;
  logic pll_n_r;
  logic r_n_r;
  logic w_n_r;
  logic is_wr_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] d_r;
  logic [LANES-1:0] bw_r;
  logic [4*DW-1:0] wbuf_r;
  logic [4*LANES-1:0] wbe_r;
  qsb_beat_t beat_r;
  logic vs1_r;
  logic vs2_r;
  logic vd_r;
  logic [DW-1:0] qs1_r;
  logic [DW-1:0] qs2_r;
  logic [3:0] cap_r;
  logic [4*DW-1:0] rdata_r;
  logic rvld_r;

  wire [1:0] ph_nxt = ph_r + 2'd1;
  wire tick_lo = (ph_r == 2'd0);
  wire tick_hi = (ph_r == 2'd2);
  wire pll_ok = I_PLL_ON && (K_MHZ >= `QSB_PLL_MIN_MHZ);
  wire pll_chg = (pll_ok != pll_n_r) && (st_r == QSB_SETUP || st_r == QSB_IDLE);
  wire setup_end = (cnt_r == SW'(SETUP_CYC - 1));
  wire accept = (st_r == QSB_IDLE) && tick_lo && !pll_chg;
  wire rd_take = accept & I_RD_REQ;
  wire wr_take = accept & I_WR_REQ & ~I_RD_REQ;
  wire cap_start = (cap_r == 4'd0) & vs2_r & ~vd_r;
  wire cap_last = (cap_r == 4'(`QSB_CAP_LAST));
  wire cap_take = (cap_r != 4'd0) & ~cap_r[0];
  wire [1:0] cap_beat = 2'(cap_r[3:1] - 3'd1);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      QSB_SETUP: if (setup_end) st_nxt = QSB_IDLE;
      QSB_IDLE: if (rd_take || wr_take) st_nxt = QSB_SEL;
      QSB_SEL: if (tick_hi) st_nxt = is_wr_r ? QSB_WDAT : QSB_RWAIT;
      QSB_WDAT: if (tick_hi && beat_r == 2'd3) st_nxt = QSB_IDLE;
      QSB_RWAIT: if (cap_last) st_nxt = QSB_IDLE;
    endcase
    if (pll_chg) begin
      st_nxt = QSB_SETUP;
    end
  end

  // K divider, parked K low and /K high in reset
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ph_r <= 2'd0;
      k_r <= 1'b0;
      kn_r <= 1'b1;
    end else begin
      ph_r <= ph_nxt;
      k_r <= ph_nxt[1];
      kn_r <= ~ph_nxt[1];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      st_r <= QSB_SETUP;
      cnt_r <= '0;
      pll_n_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_r == QSB_SETUP && !pll_chg) ? cnt_r + SW'(1) : '0;
      pll_n_r <= pll_ok;
    end
  end

  // Selects launch mid-low before the sampling K edge, release mid-high
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      r_n_r <= 1'b1;
      w_n_r <= 1'b1;
      is_wr_r <= 1'b0;
      beat_r <= 2'd0;
    end else begin
      if (rd_take) begin
        r_n_r <= 1'b0;
        is_wr_r <= 1'b0;
      end else if (wr_take) begin
        w_n_r <= 1'b0;
        is_wr_r <= 1'b1;
      end else if (st_r == QSB_SEL && tick_hi) begin
        r_n_r <= 1'b1;
        w_n_r <= 1'b1;
        beat_r <= 2'd0;
      end
      if (st_r == QSB_WDAT && (tick_lo || tick_hi)) begin
        beat_r <= beat_r + 2'd1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      addr_r <= '0;
      d_r <= '0;
      bw_r <= '1;
      wbuf_r <= '0;
      wbe_r <= '1;
    end else begin
      if (rd_take || wr_take) begin
        addr_r <= I_ADDR;
        wbuf_r <= I_WDATA;
        wbe_r <= I_WBE_N;
      end
      if (st_r == QSB_WDAT && (tick_lo || tick_hi)) begin
        d_r <= wbuf_r[beat_r*DW +: DW];
        bw_r <= wbe_r[beat_r*LANES +: LANES];
      end
    end
  end

  // Returned read stream: two flops, then a fixed-length beat counter started by the valid rise
  always_ff @(posedge I_CLK) begin
    vs1_r <= LINK.read_valid_flag;
    vs2_r <= vs1_r;
    qs1_r <= LINK.q;
    qs2_r <= qs1_r;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      vd_r <= 1'b0;
      cap_r <= 4'd0;
      rdata_r <= '0;
      rvld_r <= 1'b0;
    end else begin
      vd_r <= vs2_r;
      rvld_r <= cap_last;
      if (cap_start) begin
        cap_r <= 4'd1;
      end else if (cap_last) begin
        cap_r <= 4'd0;
      end else if (cap_r != 4'd0) begin
        cap_r <= cap_r + 4'd1;
      end
      if (cap_take) begin
        rdata_r[cap_beat*DW +: DW] <= qs2_r;
      end
    end
  end

  assign LINK.k = k_r;
  assign LINK.k_n = kn_r;
  assign LINK.r_n = r_n_r;
  assign LINK.w_n = w_n_r;
  assign LINK.pll_bypass_n = pll_n_r;
  assign LINK.addr = addr_r;
  assign LINK.d = d_r;
  assign LINK.byte_lane_write_n = bw_r;

  assign O_REQ_READY = accept;
  assign O_SETUP_DONE = (st_r != QSB_SETUP);
  assign O_RDATA = rdata_r;
  assign O_RDATA_VLD = rvld_r;
  assign O_STATE = st_r;

endmodule : qsb_ctl

`default_nettype wire

//--- rtl/qsb_defines.svh
/*
  Shared constants for the quad-rate burst SRAM link: clock rates,
  setup time, burst and lane geometry.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef QSB_DEFINES_SVH
`define QSB_DEFINES_SVH

`define QSB_CLK_MHZ 100
`define QSB_SETUP_TIME_US 20
`define QSB_SETUP_CYC (`QSB_SETUP_TIME_US * `QSB_CLK_MHZ)
`define QSB_K_DIV 4
`define QSB_PLL_MIN_MHZ 250
`define QSB_BURST_LEN 4
`define QSB_LANE_W 9
`define QSB_DATA_W 36
`define QSB_ADDR_W 20
`define QSB_CAP_LAST 8

`endif

//--- rtl/qsb_dev.sv
/*
  SRAM device end: separate read and write burst sequencers, 4 beats each,
  data registered on K and /K rising edges, memory array inside.
  Assumes the controller makes K and /K and keeps its own setup duties.
*/
`timescale 1ns/100ps
`include "qsb_defines.svh"
`default_nettype none

module qsb_dev #(
  parameter int DW = `QSB_DATA_W,
  parameter int AW = `QSB_ADDR_W
) (
  qsb_link_if.dev LINK,
  input wire logic I_NRST,
  output logic O_BUSY,
  output logic O_RD_DROP,
  output logic O_WR_DROP
);
  import qsb_pkg::*;

  localparam int LW = `QSB_LANE_W;
  localparam int LANES = DW / LW;
  localparam int MW = AW + 2;

  if ((DW != 18 && DW != 36) || AW < 1) begin : g_bad_size
    $error("qsb_dev: data width must be 18 or 36");
  end

  if (`QSB_BURST_LEN != 4) begin : g_bad_burst
    $error("qsb_dev: burst length is fixed at four beats");
  end

  logic [DW-1:0] mem [0:(1<<MW)-1];

  logic nrst_s1_r;
  logic nrst_s2_r;
  logic rd1_r;
  logic rd2_r;
  logic rd3_r;
  logic rd4_r;
  logic wr1_r;
  logic wr2_r;
  logic wr3_r;
  logic [AW-1:0] ra1_r;
  logic [AW-1:0] ra2_r;
  logic [AW-1:0] ra3_r;
  logic [AW-1:0] ra4_r;
  logic [AW-1:0] wa1_r;
  logic [AW-1:0] wa2_r;
  logic [AW-1:0] wa3_r;
  logic [DW-1:0] dp_r;
  logic [LANES-1:0] bep_r;
  logic [DW-1:0] qp_r;
  logic oep_r;
  logic busy_r;
  logic rd_drop_r;
  logic wr_drop_r;
  logic [DW-1:0] dn_r;
  logic [LANES-1:0] ben_r;
  logic [DW-1:0] qn_r;
  logic oen_r;
  logic vld_r;
  logic r_low_r;
  logic w_low_r;

  wire run = nrst_s2_r;
  // Reads win over writes; a select repeated on the next edge is dropped
  wire rd_req = ~LINK.r_n;
  wire wr_req = ~LINK.w_n;
  // A start needs its select high at the previous rising K
  wire rd_go = rd_req & ~r_low_r;
  wire wr_go = wr_req & ~rd_req & ~w_low_r;
  wire rd_drop = rd_req & r_low_r;
  wire wr_drop = wr_req & (rd_req | w_low_r);

  // Two internal low address bits walk the burst in fixed order
  wire [MW-1:0] rp_idx = rd2_r ? {ra2_r, 2'd0} : {ra3_r, 2'd2};
  wire [MW-1:0] rn_idx = rd3_r ? {ra3_r, 2'd1} : {ra4_r, 2'd3};
  wire [MW-1:0] wp_idx = wr2_r ? {wa2_r, 2'd0} : {wa3_r, 2'd2};
  wire [MW-1:0] wn_idx = {wp_idx[MW-1:1], 1'b1};
  wire wr_now = wr2_r | wr3_r;
  wire busy_nxt = rd1_r | rd2_r | rd3_r | rd4_r | wr1_r | wr2_r | wr3_r;

  // Reset arrives from outside the link clock
  always_ff @(posedge LINK.k) begin
    nrst_s1_r <= I_NRST;
    nrst_s2_r <= nrst_s1_r;
  end

  // Sequencers on rising K
  always_ff @(posedge LINK.k) begin
    if (!run) begin
      rd1_r <= 1'b0;
      rd2_r <= 1'b0;
      rd3_r <= 1'b0;
      rd4_r <= 1'b0;
      wr1_r <= 1'b0;
      wr2_r <= 1'b0;
      wr3_r <= 1'b0;
      oep_r <= 1'b0;
      busy_r <= 1'b0;
      rd_drop_r <= 1'b0;
      wr_drop_r <= 1'b0;
      r_low_r <= 1'b0;
      w_low_r <= 1'b0;
    end else begin
      rd1_r <= rd_go;
      rd2_r <= rd1_r;
      rd3_r <= rd2_r;
      rd4_r <= rd3_r;
      wr1_r <= wr_go;
      wr2_r <= wr1_r;
      wr3_r <= wr2_r;
      oep_r <= rd2_r | rd3_r;
      busy_r <= busy_nxt;
      rd_drop_r <= rd_drop;
      wr_drop_r <= wr_drop;
      r_low_r <= rd_req;
      w_low_r <= wr_req;
    end
  end

  // Address pipes and rising-K data capture
  always_ff @(posedge LINK.k) begin
    if (rd_go) begin
      ra1_r <= LINK.addr;
    end
    if (wr_go) begin
      wa1_r <= LINK.addr;
    end
    ra2_r <= ra1_r;
    ra3_r <= ra2_r;
    ra4_r <= ra3_r;
    wa2_r <= wa1_r;
    wa3_r <= wa2_r;
    dp_r <= LINK.d;
    bep_r <= LINK.byte_lane_write_n;
    qp_r <= mem[rp_idx];
  end

  // Rising /K: second beat of each pair, valid flag
  always_ff @(posedge LINK.k_n) begin
    dn_r <= LINK.d;
    ben_r <= LINK.byte_lane_write_n;
    qn_r <= mem[rn_idx];
  end

  always_ff @(posedge LINK.k_n) begin
    if (!run) begin
      oen_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      oen_r <= rd3_r | rd4_r;
      vld_r <= rd2_r | rd3_r;
    end
  end

  // Each beat pair lands on one rising K, gated lane by lane
  always_ff @(posedge LINK.k) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_now && !bep_r[l]) begin
        mem[wp_idx][l*LW +: LW] <= dp_r[l*LW +: LW];
      end
      if (wr_now && !ben_r[l]) begin
        mem[wn_idx][l*LW +: LW] <= dn_r[l*LW +: LW];
      end
    end
  end

  // K high shows the rising-K beat, K low the rising-/K beat
  assign LINK.q_o = LINK.k ? qp_r : qn_r;
  assign LINK.q_oe = LINK.k ? oep_r : oen_r;
  // Echo clocks run freely, matched to the output edges
  assign LINK.echo_clock_true = LINK.k;
  assign LINK.echo_clock_comp = LINK.k_n;
  assign LINK.read_valid_flag = vld_r;

  assign O_BUSY = busy_r;
  assign O_RD_DROP = rd_drop_r;
  assign O_WR_DROP = wr_drop_r;

endmodule : qsb_dev

`default_nettype wire

//--- rtl/qsb_link_if.sv
/*
  Pins between the memory controller and the SRAM device.
  Assumes the bench joins both modports; the read data bus reads zero while released.
*/
`timescale 1ns/100ps
`include "qsb_defines.svh"
`default_nettype none

interface qsb_link_if #(
  parameter int DW = `QSB_DATA_W,
  parameter int AW = `QSB_ADDR_W
);
  logic k;
  logic k_n;
  logic r_n;
  logic w_n;
  logic pll_bypass_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] d;
  logic [DW/`QSB_LANE_W-1:0] byte_lane_write_n;
  logic [DW-1:0] q_o;
  logic q_oe;
  logic echo_clock_true;
  logic echo_clock_comp;
  logic read_valid_flag;
  wire logic [DW-1:0] q;

  // Released read bus reads as zero; q_oe tells a driven bus apart
  assign q = q_oe ? q_o : '0;

  modport dev (
    input k, k_n, r_n, w_n, pll_bypass_n, addr, d, byte_lane_write_n,
    output q_o, q_oe, echo_clock_true, echo_clock_comp, read_valid_flag
  );

  modport ctl (
    output k, k_n, r_n, w_n, pll_bypass_n, addr, d, byte_lane_write_n,
    input q, echo_clock_true, echo_clock_comp, read_valid_flag
  );
endinterface : qsb_link_if

`default_nettype wire

//--- rtl/qsb_pkg.sv
/*
  Types shared by both ends of the quad-rate burst SRAM link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package qsb_pkg;

  typedef enum logic [2:0] {
    QSB_SETUP,
    QSB_IDLE,
    QSB_SEL,
    QSB_WDAT,
    QSB_RWAIT
  } qsb_ctl_state_e;

  typedef logic [1:0] qsb_beat_t;

endpackage : qsb_pkg

//--- test/qsb_link_asserts.sv
/*
  Link checker: read valid timing, select spacing, setup quiet time.
  Assumes K comes from the controller and I_NRST is the device reset.
*/
`timescale 1ns/100ps
`default_nettype none

module qsb_link_asserts #(
  parameter int SETUP_K = 480
) (
  input wire logic I_NRST,
  input wire logic k,
  input wire logic k_n,
  input wire logic r_n,
  input wire logic w_n,
  input wire logic pll_bypass_n,
  input wire logic q_oe,
  input wire logic read_valid_flag
);
  logic r_prev_r;
  logic vld_k_r;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic take_rd;

  assign take_rd = !r_n && r_prev_r;
  assign cnt_nxt = (cnt_r == 10'(SETUP_K)) ? cnt_r : cnt_r + 10'h001;

  always_ff @(posedge k) begin
    r_prev_r <= r_n;
    vld_k_r <= read_valid_flag;
    cnt_r <= I_NRST ? cnt_nxt : 10'h000;
  end

  default clocking cb @(posedge k); endclocking
  default disable iff (!I_NRST);

  a_valid_lead: assert property (take_rd |-> ##2 $rose(read_valid_flag) && !q_oe)
    else $error("valid did not rise half a cycle before data");
  a_valid_fall: assert property (take_rd ##2 !take_rd |-> ##2 q_oe && $fell(read_valid_flag))
    else $error("valid did not fall before last beat ended");
  a_valid_align: assert property (@(posedge k_n) read_valid_flag == vld_k_r)
    else $error("valid changed away from echo edges");
  a_read_beats: assert property (take_rd |-> ##3 q_oe [*2])
    else $error("read beats not driven in cycles two and three");
  a_rd_spacing: assert property (!r_n |=> r_n)
    else $error("read select low on consecutive edges");
  a_wr_spacing: assert property (!w_n |=> w_n)
    else $error("write select not returned high");
  a_pll_bypass: assert property (!pll_bypass_n)
    else $error("pll used below its frequency floor");
  a_setup_nops: assert property (cnt_r < 10'(SETUP_K) |-> r_n && w_n)
    else $error("operation issued during clock setup");
  a_idle_release: assert property (r_n [*6] |-> !q_oe)
    else $error("read bus driven while idle");

  c_read: cover property (take_rd);
  c_write: cover property (!w_n);
  c_valid_end: cover property ($fell(read_valid_flag));
endmodule : qsb_link_asserts

`default_nettype wire

//--- test/tb.sv
/*
  Bench: controller and device joined by the link; bursts are written and
  read back through the controller's user side.
  Assumes the rtl/ files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import qsb_pkg::*;
  localparam int AW = 6;
  localparam int DW = 36;
  localparam logic [AW-1:0] A_TAB [6] = '{6'h05, 6'h05, 6'h05, 6'h3F, 6'h00, 6'h00};
  localparam logic [15:0] BE_TAB [6] = '{16'h0000, 16'h7BDE, 16'hFFFF, 16'h0000, 16'h0000,
    16'h0F3C};
  logic clk;
  logic nrst;
  logic nrst_dev;
  logic pll_on;
  logic rd_req;
  logic wr_req;
  logic [AW-1:0] addr;
  logic [4*DW-1:0] wdata;
  logic [15:0] wbe_n;
  logic req_ready;
  logic setup_done;
  logic [4*DW-1:0] rdata;
  logic rdata_vld;
  qsb_ctl_state_e state;
  logic busy;
  logic rd_drop;
  logic wr_drop;
  logic drop_seen = 1'b0;
  logic [DW-1:0] mem_m [256];
  int n_mismatch = 0;
  int total_checks = 0;

  qsb_link_if #(.DW(DW), .AW(AW)) qsb_link_if_i ();

  qsb_ctl #(.DW(DW), .AW(AW)) qsb_ctl_i (
    .I_CLK(clk), .I_NRST(nrst), .I_PLL_ON(pll_on), .I_RD_REQ(rd_req), .I_WR_REQ(wr_req),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WBE_N(wbe_n), .O_REQ_READY(req_ready),
    .O_SETUP_DONE(setup_done), .O_RDATA(rdata), .O_RDATA_VLD(rdata_vld), .O_STATE(state),
    .LINK(qsb_link_if_i.ctl)
  );

  qsb_dev #(.DW(DW), .AW(AW)) qsb_dev_i (
    .LINK(qsb_link_if_i.dev), .I_NRST(nrst_dev), .O_BUSY(busy), .O_RD_DROP(rd_drop),
    .O_WR_DROP(wr_drop)
  );

  qsb_link_asserts qsb_link_asserts_i (
    .I_NRST(nrst_dev), .k(qsb_link_if_i.k), .k_n(qsb_link_if_i.k_n), .r_n(qsb_link_if_i.r_n),
    .w_n(qsb_link_if_i.w_n), .pll_bypass_n(qsb_link_if_i.pll_bypass_n),
    .q_oe(qsb_link_if_i.q_oe), .read_valid_flag(qsb_link_if_i.read_valid_flag)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (rd_drop === 1'b1 || wr_drop === 1'b1) drop_seen <= 1'b1;

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [4*DW-1:0] seen, input logic [4*DW-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // One burst; request held until the ready cycle's edge takes it
  task automatic op(input logic wr, input logic [AW-1:0] a, input logic [15:0] be, input int s);
    int n;
    logic [4*DW-1:0] wd;
    n = 0;
    tick();
    for (int i = 0; i < 4; i++) wd[36*i +: 36] = 36'h111111111 * 36'(i + 1) + 36'(s);
    addr = a;
    wdata = wd;
    wbe_n = be;
    wr_req = wr;
    rd_req = !wr;
    while (req_ready !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    tick();
    wr_req = 1'b0;
    rd_req = 1'b0;
    if (wr) begin
      for (int i = 0; i < 16; i++) if (!be[i]) mem_m[{a, 2'(i / 4)}][9*(i%4) +: 9] = wd[9*i +: 9];
    end else begin
      while (rdata_vld !== 1'b1 && n < 200) begin
        tick();
        n++;
      end
      for (int i = 0; i < 4; i++) check(rdata[36*i +: 36], mem_m[{a, 2'(i)}]);
    end
    check(n < 200, 1'b1);
  endtask : op

  initial begin
    int n;
    nrst = 1'b0;
    nrst_dev = 1'b0;
    pll_on = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr = '0;
    wdata = '0;
    wbe_n = '1;
    repeat (5) tick();
    nrst = 1'b1;
    repeat (40) tick();
    nrst_dev = 1'b1;
    check(state, QSB_SETUP);
    check(req_ready, 1'b0);
    check(qsb_link_if_i.q_oe, 1'b0);
    pll_on = 1'b1;
    n = 40;
    while (setup_done !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    check(n >= 2000 && n < 3000, 1'b1);
    for (int j = 0; j < 6; j++) begin
      op(1'b1, A_TAB[j], BE_TAB[j], j);
      op(1'b0, A_TAB[j], 16'hFFFF, 0);
    end
    op(1'b0, 6'h3F, 16'hFFFF, 0);
    repeat (20) tick();
    check(qsb_link_if_i.q_oe, 1'b0);
    check(qsb_link_if_i.pll_bypass_n, 1'b0);
    check(drop_seen, 1'b0);
    check(busy, 1'b0);
    finish_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
